//--- hw/dac_pin_mux_defs.svh
// constants for the dual converter control-pin decoder
`ifndef DAC_PIN_MUX_DEFS_SVH
`define DAC_PIN_MUX_DEFS_SVH
`define DATA_WIDTH 12
`define SYNC_STAGES 2
`define MODE_SERIAL 1'b0
`define MODE_STRAP 1'b1
`define FORMAT_BINARY 1'b0
`define FORMAT_TWOS 1'b1
`define RESET_WORD 12'h000
`endif

//--- hw/dac_pin_mux_pkg.sv
// types shared by the control-pin decoder
package dac_pin_mux_pkg;
  typedef enum logic [0:0] {
    SERIAL_MODE,
    STRAP_MODE
  } op_mode_t;
endpackage : dac_pin_mux_pkg

//--- hw/dual_dac_mode_pin_select.sv
// mode-pin decoder and shared-pin router for a dual current converter
// Behaviour
// - mode pin low selects serial port mode
// - mode pin high pulse resets serial registers
// - mode pin high selects pin-strap configuration
// - serial mode: shared pin is serial clock
// - strap mode: phase pin rising edge triggers retime
// - serial mode: data pin is bidirectional
// - format low selects straight binary
// - format high selects twos complement
// - serial mode: select pin is active-low select
// - power-down high powers down, serial alive
// - set resistor picks aux output or adjust
// - true output full at ones, complement zeros
// - data clock qualifies parallel sample words
`timescale 1ns/100ps
`include "dac_pin_mux_defs.svh"
module dual_dac_mode_pin_select (
  input  wire logic        clock_in,            // 250 MHz core clock
  input  wire logic        rst_n_in,            // async reset, active low
  input  wire logic        mode_select_pin_in,  // mode pin level
  input  wire logic        clk_phase_pin_in,    // serial clock / retime phase
  input  wire logic        data_format_pin_in,  // serial data / format pin
  input  wire logic        select_power_down_strap_pin_in, // select_n / power down
  input  wire logic        serial_dout_in,      // data from serial engine
  input  wire logic        serial_doe_in,       // serial engine drives
  input  wire logic        data_io_clock_in,    // parallel data clock pin
  input  wire logic [11:0] sample_word_in,      // parallel data pins
  input  wire logic        i_internal_set_resistor_in, // i set enable
  input  wire logic        q_internal_set_resistor_in, // q set enable
  output logic             pin_strap_mode_out,  // high in strap mode
  output logic             serial_reg_reset_out,// serial regs reset pulse
  output logic             serial_clock_out,    // serial clock level
  output logic             serial_din_out,      // serial data received
  output logic             serial_select_n_out, // chip select, low active
  output logic             sdio_out,            // data pin drive value
  output logic             sdio_oe_out,         // data pin drive enable
  output logic             twos_complement_out, // strap format
  output logic             power_down_strap_out,// core power down
  output logic             retime_trigger_out,  // one-cycle retime pulse
  output logic [11:0]      sample_word_out,     // qualified offset word
  output logic             sample_valid_out,    // new word pulse
  output logic             i_aux_out_en_out,    // i pin is aux output
  output logic             q_aux_out_en_out     // q pin is aux output
);
  // all state in one struct
  typedef struct packed {
    logic [1:0]  mode_sync;   // mode pin synchroniser
    logic [1:0]  clk_sync;    // clock/phase pin synchroniser
    logic [1:0]  dat_sync;    // data/format synchroniser
    logic [1:0]  sel_sync;    // select/power synchroniser
    logic [1:0]  dclk_sync;   // data clock synchroniser
    logic [1:0]  iset_sync;   // i set enable synchroniser
    logic [1:0]  qset_sync;   // q set enable synchroniser
    logic        mode_prev;   // last stable mode
    logic        phase_prev;  // last stable phase pin
    logic        dclk_prev;   // last stable data clock
    logic [11:0] word_cap;    // captured data word
    logic [11:0] word_s2;     // second stage word
    logic        strap;       // strap mode output
    logic        reg_rst;     // serial reset pulse
    logic        sclk;        // serial clock
    logic        sdin;        // serial data in
    logic        csn;         // select
    logic        sdo;         // drive value
    logic        sdoe;        // drive enable
    logic        twos;        // format
    logic        pdn;         // power down
    logic        retime;      // retime pulse
    logic [11:0] word;        // output word
    logic        valid;       // word pulse
    logic        iaux;        // i aux route
    logic        qaux;        // q aux route
  } state_t;

  state_t state_ff;
  state_t nxt_state;
  dac_pin_mux_pkg::op_mode_t mode_w;

  // next-state logic; only second sync stages are read
  always_comb begin
    nxt_state = state_ff;
    nxt_state.mode_sync = {state_ff.mode_sync[0], mode_select_pin_in};
    nxt_state.clk_sync  = {state_ff.clk_sync[0], clk_phase_pin_in};
    nxt_state.dat_sync  = {state_ff.dat_sync[0], data_format_pin_in};
    nxt_state.sel_sync  = {state_ff.sel_sync[0], select_power_down_strap_pin_in};
    nxt_state.dclk_sync = {state_ff.dclk_sync[0], data_io_clock_in};
    nxt_state.iset_sync = {state_ff.iset_sync[0],
                           i_internal_set_resistor_in};
    nxt_state.qset_sync = {state_ff.qset_sync[0],
                           q_internal_set_resistor_in};
    // parallel word passes two stages like every other pin
    nxt_state.word_cap = sample_word_in;
    nxt_state.word_s2  = state_ff.word_cap;
    mode_w = state_ff.mode_sync[1] ? dac_pin_mux_pkg::STRAP_MODE
                                   : dac_pin_mux_pkg::SERIAL_MODE;
    nxt_state.mode_prev  = state_ff.mode_sync[1];
    nxt_state.phase_prev = state_ff.clk_sync[1];
    nxt_state.dclk_prev  = state_ff.dclk_sync[1];
    nxt_state.strap   = (mode_w == dac_pin_mux_pkg::STRAP_MODE);
    nxt_state.reg_rst = 1'b0;
    nxt_state.retime  = 1'b0;
    case (mode_w)
      dac_pin_mux_pkg::SERIAL_MODE: begin
        nxt_state.sclk = state_ff.clk_sync[1];
        nxt_state.sdin = state_ff.dat_sync[1];
        nxt_state.csn  = state_ff.sel_sync[1];
        // drive only while selected; avoids contention when idle
        nxt_state.sdoe = serial_doe_in & ~state_ff.sel_sync[1];
        nxt_state.sdo  = serial_dout_in;
        // strap functions hold their last value here
      end
      dac_pin_mux_pkg::STRAP_MODE: begin
        // a high pulse from serial mode resets the serial registers;
        // it also leaves the regs at default if the pin stays high
        nxt_state.reg_rst = ~state_ff.mode_prev;
        nxt_state.twos = state_ff.dat_sync[1];
        nxt_state.pdn  = state_ff.sel_sync[1];
        // the host ties the pin low for equal clocks: no edge
        nxt_state.retime = state_ff.clk_sync[1] & ~state_ff.phase_prev;
        // serial side quiet, serial logic itself stays powered
        nxt_state.sclk = 1'b0;
        nxt_state.sdin = 1'b0;
        nxt_state.csn  = 1'b1;
        nxt_state.sdoe = 1'b0;
        nxt_state.sdo  = 1'b0;
      end
      default: begin
        nxt_state.csn = 1'b1;
      end
    endcase
    if (mode_w == dac_pin_mux_pkg::STRAP_MODE && state_ff.clk_sync[1]
        && !state_ff.phase_prev) begin
      nxt_state.retime = 1'b1;
    end
    // data clock rising edge qualifies the word
    nxt_state.valid = state_ff.dclk_sync[1] & ~state_ff.dclk_prev;
    if (state_ff.dclk_sync[1] && !state_ff.dclk_prev) begin
      // twos complement flips msb so all ones is full scale
      nxt_state.word = state_ff.twos
        ? {~state_ff.word_s2[11], state_ff.word_s2[10:0]}
        : state_ff.word_s2;
    end
    nxt_state.iaux = state_ff.iset_sync[1];
    nxt_state.qaux = state_ff.qset_sync[1];
  end

  // single state register, constant reset values
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff      <= '0;
      state_ff.csn  <= 1'b1;
      state_ff.word <= `RESET_WORD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from flops
  assign pin_strap_mode_out   = state_ff.strap;
  assign serial_reg_reset_out = state_ff.reg_rst;
  assign serial_clock_out     = state_ff.sclk;
  assign serial_din_out       = state_ff.sdin;
  assign serial_select_n_out  = state_ff.csn;
  assign sdio_out             = state_ff.sdo;
  assign sdio_oe_out          = state_ff.sdoe;
  assign twos_complement_out  = state_ff.twos;
  assign power_down_strap_out = state_ff.pdn;
  assign retime_trigger_out   = state_ff.retime;
  assign sample_word_out      = state_ff.word;
  assign sample_valid_out     = state_ff.valid;
  assign i_aux_out_en_out     = state_ff.iaux;
  assign q_aux_out_en_out     = state_ff.qaux;

  // named steps of the edge-driven behaviours
  // strap flag goes from low to high
  sequence strap_entry_s;
    !pin_strap_mode_out ##1 pin_strap_mode_out;
  endsequence
  // synced phase pin rises
  sequence phase_rise_s;
    !state_ff.clk_sync[1] ##1 state_ff.clk_sync[1];
  endsequence
  // synced data clock rises
  sequence dclk_rise_s;
    !state_ff.dclk_sync[1] ##1 state_ff.dclk_sync[1];
  endsequence

  // assertions
  strap_follow_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    pin_strap_mode_out == $past(state_ff.mode_sync[1]))
    else $error("strap flag wrong");
  serial_quiet_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    pin_strap_mode_out |-> !sdio_oe_out && serial_select_n_out)
    else $error("serial active in strap");
  retime_pulse_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    retime_trigger_out |=> !retime_trigger_out)
    else $error("retime not one cycle");
  retime_mode_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    retime_trigger_out |-> pin_strap_mode_out)
    else $error("retime in serial mode");
  // a rising phase pin in strap mode must fire the retime
  retime_edge_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    phase_rise_s ##0 state_ff.mode_sync[1] |=> retime_trigger_out)
    else $error("retime edge missed");
  reset_pulse_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    serial_reg_reset_out |=> !serial_reg_reset_out)
    else $error("reg reset not a pulse");
  // every entry into strap mode resets the serial registers
  reset_on_entry_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    strap_entry_s |-> serial_reg_reset_out)
    else $error("no reg reset on entry");
  sdio_sel_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    sdio_oe_out |-> !$past(state_ff.sel_sync[1]))
    else $error("drive without select");
  aux_route_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    i_aux_out_en_out == $past(state_ff.iset_sync[1]))
    else $error("aux route wrong");
  q_aux_route_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    q_aux_out_en_out == $past(state_ff.qset_sync[1]))
    else $error("q aux route wrong");
  valid_pulse_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    sample_valid_out |=> !sample_valid_out)
    else $error("valid not a pulse");
  // a rising data clock must hand a word on
  valid_edge_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    dclk_rise_s |=> sample_valid_out)
    else $error("data clock edge missed");
  // strap levels are frozen while serial mode is selected
  strap_hold_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    !state_ff.mode_sync[1] |=>
      $stable({twos_complement_out, power_down_strap_out}))
    else $error("strap level moved in serial");
endmodule : dual_dac_mode_pin_select

//--- verification/host_pin_model.sv
// host-side driver of the mode, strap and shared serial pins
`timescale 1ns/100ps
module host_pin_model (
  input  wire logic clock_in,      // core clock
  input  wire logic mode_req_in,   // wanted mode pin level
  input  wire logic phase_req_in,  // wanted phase pin level
  input  wire logic same_clk_in,   // data clock equals sampling clock
  input  wire logic fmt_req_in,    // host level on the data pin
  input  wire logic sel_req_in,    // host level on select pin
  input  wire logic dev_oe_in,     // device drives the data pin
  input  wire logic dev_d_in,      // device data pin value
  output logic      mode_pin_out,  // mode pin
  output logic      phase_pin_out, // clock / phase pin
  output logic      data_pin_out,  // resolved data pin level
  output logic      sel_pin_out    // select / power-down pin
);
  logic host_d_ff = 1'b0;  // host level on the data pin
  initial mode_pin_out = 1'b0;
  initial phase_pin_out = 1'b0;
  initial sel_pin_out = 1'b1;
  // pins move just after the edge, like a real host
  always @(posedge clock_in) begin
    mode_pin_out <= mode_req_in;
    // same clocks: phase pin is tied low, else edge passes
    phase_pin_out <= same_clk_in ? 1'b0 : phase_req_in;
    host_d_ff <= fmt_req_in;
    sel_pin_out <= sel_req_in;
  end
  // host lets go of the data line while the device drives it
  assign data_pin_out = dev_oe_in ? dev_d_in : host_d_ff;
endmodule : host_pin_model

//--- verification/tb_top.sv
// self-checking bench for the converter control-pin decoder
`timescale 1ns/100ps
module tb_top;
  logic clock_in = 1'b0, rst_n_in = 1'b0, mode_req = 1'b0, phase_req = 1'b0;
  logic same_clk = 1'b0, fmt_req = 1'b0, sel_req = 1'b1;
  logic serial_dout_in = 1'b0, serial_doe_in = 1'b0, data_io_clock_in = 1'b0;
  logic [11:0] sample_word_in = 12'h000;
  logic i_internal_set_resistor_in = 1'b0, q_internal_set_resistor_in = 1'b0;
  wire mode_select_pin_in, clk_phase_pin_in;
  wire data_format_pin_in, select_power_down_strap_pin_in;
  logic pin_strap_mode_out, serial_reg_reset_out, serial_clock_out;
  logic serial_din_out, serial_select_n_out, sdio_out, sdio_oe_out;
  logic twos_complement_out, power_down_strap_out, retime_trigger_out;
  logic [11:0] sample_word_out;
  logic sample_valid_out, i_aux_out_en_out, q_aux_out_en_out;
  int miscompares = 0, checks_done = 0;
  logic [11:0] n_rst = 12'h000, n_ret = 12'h000, n_val = 12'h000; // pulses
  always #2 clock_in = ~clock_in;
  // count pulses on the falling edge, away from their launch
  always @(negedge clock_in) begin
    n_rst += {11'h000, serial_reg_reset_out};
    n_ret += {11'h000, retime_trigger_out};
    n_val += {11'h000, sample_valid_out};
  end
  host_pin_model host (.clock_in, .mode_req_in(mode_req),
    .phase_req_in(phase_req), .same_clk_in(same_clk), .fmt_req_in(fmt_req),
    .sel_req_in(sel_req), .dev_oe_in(sdio_oe_out), .dev_d_in(sdio_out),
    .mode_pin_out(mode_select_pin_in), .phase_pin_out(clk_phase_pin_in),
    .data_pin_out(data_format_pin_in), .sel_pin_out(select_power_down_strap_pin_in));
  dual_dac_mode_pin_select dut (.clock_in, .rst_n_in, .mode_select_pin_in,
    .clk_phase_pin_in, .data_format_pin_in, .select_power_down_strap_pin_in,
    .serial_dout_in, .serial_doe_in, .data_io_clock_in, .sample_word_in,
    .i_internal_set_resistor_in, .q_internal_set_resistor_in,
    .pin_strap_mode_out, .serial_reg_reset_out, .serial_clock_out,
    .serial_din_out, .serial_select_n_out, .sdio_out, .sdio_oe_out,
    .twos_complement_out, .power_down_strap_out, .retime_trigger_out,
    .sample_word_out, .sample_valid_out, .i_aux_out_en_out,
    .q_aux_out_en_out);
  // one compare for every level, word and pulse count
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // data line turnaround takes seven edges to show; ten leaves margin
  task automatic settle();
    repeat (10) @(posedge clock_in);
  endtask : settle
  task automatic report_and_stop();
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // serial mode: shared pins pass through, data line turns around
  task automatic t_serial();
    @(posedge clock_in);
    phase_req <= 1'b1; fmt_req <= 1'b1; sel_req <= 1'b0;
    serial_doe_in <= 1'b1;
    settle();
    chk(pin_strap_mode_out, 12'h000);
    chk(serial_clock_out, 12'h001);
    chk(serial_select_n_out, 12'h000);
    chk({sdio_oe_out, sdio_out, serial_din_out}, 12'h004);
    chk(n_ret, 12'h000);
    // deselected: the engine's drive request must not reach the pin
    serial_dout_in <= 1'b1; phase_req <= 1'b0; sel_req <= 1'b1;
    settle();
    chk(serial_select_n_out, 12'h001);
    chk(serial_clock_out, 12'h000);
    chk({sdio_oe_out, sdio_out, serial_din_out}, 12'h003);
    chk({twos_complement_out, power_down_strap_out}, 12'h000);
  endtask : t_serial
  // mode pin rises: one register reset, strap mode, serial outputs idle
  task automatic t_strap();
    mode_req <= 1'b1;
    settle();
    chk(n_rst, 12'h001);
    chk(pin_strap_mode_out, 12'h001);
    chk(serial_select_n_out, 12'h001);
    chk({serial_clock_out, sdio_oe_out}, 12'h000);
  endtask : t_strap
  // strap levels, then retime with equal and unequal clocks
  task automatic t_pins();
    for (int f = 0; f < 2; f++) begin
      fmt_req <= f[0]; sel_req <= f[0];
      settle();
      chk(twos_complement_out, f[11:0]);
      chk(power_down_strap_out, f[11:0]);
    end
    same_clk <= 1'b1; phase_req <= 1'b1;
    settle();
    chk(n_ret, 12'h000);
    same_clk <= 1'b0; phase_req <= 1'b0;
    settle();
    phase_req <= 1'b1;
    settle();
    chk(n_ret, 12'h001);
  endtask : t_pins
  // each data clock rise hands one word on, offset when twos complement
  task automatic t_words();
    for (int f = 0; f < 2; f++) begin
      fmt_req <= f[0]; sample_word_in <= 12'h3A5;
      settle();
      data_io_clock_in <= 1'b1;
      settle();
      data_io_clock_in <= 1'b0;
      chk(sample_word_out, f ? 12'hBA5 : 12'h3A5);
      chk(n_val, f[11:0] + 12'h001);
    end
  endtask : t_words
  // set resistor enable picks aux output per channel
  task automatic t_aux();
    for (int f = 0; f < 2; f++) begin
      i_internal_set_resistor_in <= f[0];
      q_internal_set_resistor_in <= ~f[0];
      settle();
      chk({i_aux_out_en_out, q_aux_out_en_out}, 12'h001 << f);
    end
  endtask : t_aux
  // watchdog in case a wait never ends
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_serial();
    t_strap();
    t_pins();
    t_words();
    t_aux();
    report_and_stop();
  end
endmodule : tb_top
